// File: hw/cce_exec.sv
// Purpose: executes clear-accumulator, complement, watchdog-clear and decrement
// Assumes: APB slave, one wait state on every access, rst_n synchronous
// Notes: an instruction is issued by writing its code to the opcode register;
//        it executes at the same edge that completes the write
module cce_exec #(
	parameter int FILE_DEPTH = cce_pkg::FILE_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cce_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// watchdog side effects, one-cycle pulses
	output logic watchdogCounterClear,
	output logic prescalerClear,
	// core status flags
	output logic nullResultFlag,
	output logic timeoutFlag,
	output logic powerDownFlag
);

	// ==========================================================
	// state
	logic preadyReg, preadyNext;
	logic pslverrReg, pslverrNext;
	logic [31:0] prdataReg, prdataNext;
	logic [cce_pkg::DATA_W-1:0] accReg, accNext;
	logic [cce_pkg::OPC_W-1:0] opcodeReg, opcodeNext;
	logic [cce_pkg::IDX_W-1:0] fileIdxReg, fileIdxNext;
	logic nullReg, nullNext;
	logic timeoutReg, timeoutNext;
	logic powerDownReg, powerDownNext;
	logic wdClearReg, presClearReg;
	logic [cce_pkg::DATA_W-1:0] fileMem [FILE_DEPTH];

	// ==========================================================
	// bus decode
	wire logic accessDone = psel & penable & preadyReg;
	wire logic wrStrobe = accessDone & pwrite;
	wire logic hitOpcode = (paddr == cce_pkg::OFF_OPCODE);
	wire logic hitAcc = (paddr == cce_pkg::OFF_ACC);
	wire logic hitStatus = (paddr == cce_pkg::OFF_STATUS);
	wire logic hitIdx = (paddr == cce_pkg::OFF_FILE_IDX);
	wire logic hitData = (paddr == cce_pkg::OFF_FILE_DATA);
	wire logic mapped = hitOpcode | hitAcc | hitStatus | hitIdx | hitData;
	wire logic issue = wrStrobe & hitOpcode;

	// ==========================================================
	// instruction decode
	wire logic [cce_pkg::OPC_W-1:0] word = pwdata[cce_pkg::OPC_W-1:0];
	wire logic [5:0] wordHi = word[cce_pkg::OPC_W-1:cce_pkg::OPC_HI_LSB];
	cce_pkg::cce_dec_s dec;
	cce_pkg::cce_op_e decOp;
	// full-word matches first; the two operand forms match on the top six bits
	assign decOp = !issue ? cce_pkg::OP_NONE
		: (word == cce_pkg::OPC_CLEAR_ACC) ? cce_pkg::OP_CLEAR_ACC
		: (word == cce_pkg::OPC_WATCHDOG_CLEAR) ? cce_pkg::OP_WATCHDOG_CLEAR
		: (wordHi == cce_pkg::OPC_COMPLEMENT_HI) ? cce_pkg::OP_COMPLEMENT
		: (wordHi == cce_pkg::OPC_DECREMENT_HI) ? cce_pkg::OP_DECREMENT
		: cce_pkg::OP_NONE;
	// one assignment for the whole struct keeps a single driver on it
	assign dec = '{
		op: decOp,
		toFile: word[cce_pkg::DEST_BIT],
		idx: word[cce_pkg::IDX_W-1:0]
	};

	// ==========================================================
	// datapath: operand, results, zero test
	wire logic [cce_pkg::DATA_W-1:0] operand = fileMem[dec.idx];
	wire logic isComp = (dec.op == cce_pkg::OP_COMPLEMENT);
	wire logic isDec = (dec.op == cce_pkg::OP_DECREMENT);
	wire logic isArith = isComp | isDec;
	wire logic [cce_pkg::DATA_W-1:0] result = isComp ? ~operand
		: operand - cce_pkg::DEC_STEP;
	wire logic resultZero = (result == cce_pkg::ZERO_BYTE);
	wire logic toAcc = isArith & ~dec.toFile;
	wire logic toFileOp = isArith & dec.toFile;
	wire logic isClrAcc = (dec.op == cce_pkg::OP_CLEAR_ACC);
	wire logic isWdClr = (dec.op == cce_pkg::OP_WATCHDOG_CLEAR);
	wire logic fileSwWrite = wrStrobe & hitData;
	wire logic [cce_pkg::DATA_W-1:0] swByte = pwdata[cce_pkg::DATA_W-1:0];

	// ==========================================================
	// next-state for accumulator, flags, opcode and index
	assign accNext = isClrAcc ? cce_pkg::ACC_RESET
		: toAcc ? result
		: (wrStrobe & hitAcc) ? swByte
		: accReg;
	// an instruction result outranks a software write of the status word
	assign nullNext = isClrAcc ? 1'b1
		: isArith ? resultZero
		: (wrStrobe & hitStatus) ? pwdata[cce_pkg::ST_NULL]
		: nullReg;
	// hardware set wins over a software clear in the same cycle
	assign timeoutNext = isWdClr |
		((wrStrobe & hitStatus) ? pwdata[cce_pkg::ST_TIMEOUT] : timeoutReg);
	assign powerDownNext = isWdClr |
		((wrStrobe & hitStatus) ? pwdata[cce_pkg::ST_POWERDOWN] : powerDownReg);
	assign opcodeNext = issue ? word : opcodeReg;
	assign fileIdxNext = (wrStrobe & hitIdx) ? pwdata[cce_pkg::IDX_W-1:0] : fileIdxReg;

	// ==========================================================
	// bus answer: one wait state keeps every output on a flop
	assign preadyNext = psel & penable & ~preadyReg;
	assign pslverrNext = preadyNext & ~mapped;
	assign prdataNext = (!preadyNext || pwrite) ? 32'h0000_0000
		: hitOpcode ? {18'h00000, opcodeReg}
		: hitAcc ? {24'h000000, accReg}
		: hitStatus ? {29'h00000000, powerDownReg, timeoutReg, nullReg}
		: hitIdx ? {25'h0000000, fileIdxReg}
		: hitData ? {24'h000000, fileMem[fileIdxReg]}
		: 32'h0000_0000;

	// control registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			preadyReg <= 1'b0;
			pslverrReg <= 1'b0;
			prdataReg <= 32'h0000_0000;
			accReg <= cce_pkg::ACC_RESET;
			opcodeReg <= cce_pkg::OPCODE_RESET;
			fileIdxReg <= cce_pkg::IDX_RESET;
			nullReg <= cce_pkg::FLAG_NULL_RESET;
			timeoutReg <= cce_pkg::FLAG_TIMEOUT_RESET;
			powerDownReg <= cce_pkg::FLAG_POWERDOWN_RESET;
			wdClearReg <= 1'b0;
			presClearReg <= 1'b0;
		end else begin
			preadyReg <= preadyNext;
			pslverrReg <= pslverrNext;
			prdataReg <= prdataNext;
			accReg <= accNext;
			opcodeReg <= opcodeNext;
			fileIdxReg <= fileIdxNext;
			nullReg <= nullNext;
			timeoutReg <= timeoutNext;
			powerDownReg <= powerDownNext;
			wdClearReg <= isWdClr;
			presClearReg <= isWdClr;
		end
	end

	// register file; no reset, software must load it before use
	always_ff @(posedge ref_clk) begin
		if (toFileOp) begin
			fileMem[dec.idx] <= result;
		end else if (fileSwWrite) begin
			fileMem[fileIdxReg] <= swByte;
		end
	end

	// ==========================================================
	// outputs
	assign prdata = prdataReg;
	assign pready = preadyReg;
	assign pslverr = pslverrReg;
	assign watchdogCounterClear = wdClearReg;
	assign prescalerClear = presClearReg;
	assign nullResultFlag = nullReg;
	assign timeoutFlag = timeoutReg;
	assign powerDownFlag = powerDownReg;

endmodule

// File: hw/cce_pkg.sv
// Purpose: shared constants and types for the clear/complement/decrement executor
// Assumes: 14-bit instruction words, 8-bit data path, APB register access
// Notes: register map offsets are byte addresses of aligned 32-bit words
//
// Behaviour
// - clear-accumulator opcode 0x0103 loads zero into accumulator, sets null flag
// - complement opcode writes inverse of addressed register, updates null flag
// - complement destination bit 0 targets accumulator, 1 targets the register
// - watchdog-clear opcode 0x0064 clears watchdog counter and its prescaler
// - watchdog-clear sets timeout and power-down flags, touches nothing else
// - decrement opcode writes addressed register minus one, updates null flag
// - decrement destination bit 0 targets accumulator, 1 targets the register
// - register operand index 0..127 in low seven bits, one destination bit
package cce_pkg;

	// ==========================================================
	// sizes
	localparam int DATA_W = 8;
	localparam int OPC_W = 14;
	localparam int IDX_W = 7;
	localparam int FILE_DEPTH = 128;
	localparam int ADDR_W = 8;

	// ==========================================================
	// instruction encodings
	localparam logic [OPC_W-1:0] OPC_CLEAR_ACC = 14'h0103;
	localparam logic [OPC_W-1:0] OPC_WATCHDOG_CLEAR = 14'h0064;
	localparam logic [5:0] OPC_COMPLEMENT_HI = 6'h09;
	localparam logic [5:0] OPC_DECREMENT_HI = 6'h03;
	localparam int OPC_HI_LSB = 8;
	localparam int DEST_BIT = 7;

	// ==========================================================
	// register map (byte offsets)
	localparam logic [ADDR_W-1:0] OFF_OPCODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_ACC = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_FILE_IDX = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_FILE_DATA = 8'h10;

	// ==========================================================
	// status field positions and reset values
	localparam int ST_NULL = 0;
	localparam int ST_TIMEOUT = 1;
	localparam int ST_POWERDOWN = 2;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [OPC_W-1:0] OPCODE_RESET = 14'h0000;
	localparam logic [IDX_W-1:0] IDX_RESET = 7'h00;
	localparam logic FLAG_NULL_RESET = 1'b0;
	localparam logic FLAG_TIMEOUT_RESET = 1'b1;
	localparam logic FLAG_POWERDOWN_RESET = 1'b1;
	localparam logic [DATA_W-1:0] DEC_STEP = 8'h01;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	// ==========================================================
	// decoded instruction
	typedef enum logic [2:0] {
		OP_NONE,
		OP_CLEAR_ACC,
		OP_COMPLEMENT,
		OP_WATCHDOG_CLEAR,
		OP_DECREMENT
	} cce_op_e;

	typedef struct packed {
		cce_op_e op;
		logic toFile;
		logic [IDX_W-1:0] idx;
	} cce_dec_s;

endpackage

// File: bench/cce_exec_monitor.sv
// Purpose: port-level checks on the instruction executor
// Assumes: one wait state; an instruction runs at the edge completing its write
// Notes: operand file is internal, so operand results are judged by the bench
module cce_exec_monitor #(
	parameter int FILE_DEPTH = cce_pkg::FILE_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cce_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// side effects and flags
	input wire logic watchdogCounterClear,
	input wire logic prescalerClear,
	input wire logic nullResultFlag,
	input wire logic timeoutFlag,
	input wire logic powerDownFlag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// instruction issue, seen only at the completing edge
	wire opWrite = psel && penable && pready && pwrite && paddr == cce_pkg::OFF_OPCODE;
	wire clrAcc = opWrite && pwdata[13:0] == cce_pkg::OPC_CLEAR_ACC;
	wire wdClr = opWrite && pwdata[13:0] == cce_pkg::OPC_WATCHDOG_CLEAR;
	// ==========
	// bus timing and instruction effects
	one_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("ready not given after one wait");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data leaks");
	clear_acc_a: assert property (clrAcc |=> nullResultFlag)
		else $error("zero flag not set by clear");
	wd_pulse_a: assert property (wdClr |=> watchdogCounterClear && prescalerClear)
		else $error("watchdog clears missing");
	wd_flags_a: assert property (
		wdClr |=> timeoutFlag && powerDownFlag && nullResultFlag == $past(nullResultFlag))
		else $error("watchdog clear flag effect wrong");
	pulse_cause_a: assert property (watchdogCounterClear |-> $past(wdClr) ##1 !watchdogCounterClear)
		else $error("stray watchdog clear pulse");
endmodule

bind cce_exec cce_exec_monitor #(.FILE_DEPTH(FILE_DEPTH)) i_mon (.ref_clk(ref_clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.watchdogCounterClear(watchdogCounterClear), .prescalerClear(prescalerClear),
	.nullResultFlag(nullResultFlag), .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag));

// File: bench/tb_clear_complement_decrement_exec.sv
// Purpose: directed tests of the instruction executor over apb
// Assumes: operand file written before it is used
// Notes: watchdog pulses are judged by the monitor
module tb_clear_complement_decrement_exec;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// stimulus and observed signals
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] rdVal;
	logic rdErr;
	logic nullFlag;
	logic toFlag;
	logic pdFlag;
	logic wdClr;
	logic presClr;
	int wdCount = 0;
	int presCount = 0;
	int errTotal = 0;
	int checkCount = 0;
	always #5 ref_clk = ~ref_clk;
	cce_exec i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .watchdogCounterClear(wdClr), .prescalerClear(presClr),
		.nullResultFlag(nullFlag), .timeoutFlag(toFlag), .powerDownFlag(pdFlag));
	// count pulse cycles so a stuck or doubled pulse shows as a wrong total
	always @(posedge ref_clk) begin
		if (wdClr === 1'h1) begin
			wdCount++;
		end
		if (presClr === 1'h1) begin
			presCount++;
		end
	end
	// one transfer; held until pready is sampled high, the watchdog ends a dead slave
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'h1);
		rdVal = prdata;
		rdErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checkCount++;
		if (g !== e) begin
			errTotal++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(nm, e, rdVal);
	endtask
	// load one operand then issue the instruction
	task automatic op(input logic [6:0] i, input logic [7:0] v, input logic [13:0] c);
		apb(1'h1, cce_pkg::OFF_FILE_IDX, {25'h0, i});
		apb(1'h1, cce_pkg::OFF_FILE_DATA, {24'h0, v});
		apb(1'h1, cce_pkg::OFF_OPCODE, {18'h0, c});
	endtask
	task automatic t_clear();
		rd("status", cce_pkg::OFF_STATUS, 32'h6);
		chk("flag pins", 32'h6, {29'h0, pdFlag, toFlag, nullFlag});
		apb(1'h1, cce_pkg::OFF_ACC, 32'h5a);
		apb(1'h1, cce_pkg::OFF_STATUS, 32'h0);
		apb(1'h1, cce_pkg::OFF_OPCODE, 32'h0103);
		rd("acc", cce_pkg::OFF_ACC, 32'h0);
		rd("status", cce_pkg::OFF_STATUS, 32'h1);
		chk("flag pins", 32'h1, {29'h0, pdFlag, toFlag, nullFlag});
	endtask
	// unknown code is stored but runs nothing; upper write bits are dropped
	task automatic t_none();
		apb(1'h1, cce_pkg::OFF_OPCODE, 32'hffff_ffff);
		rd("opcode", cce_pkg::OFF_OPCODE, 32'h3fff);
		rd("acc", cce_pkg::OFF_ACC, 32'hff);
		rd("status", cce_pkg::OFF_STATUS, 32'h6);
	endtask
	// top and bottom index, both destinations
	task automatic t_comp();
		op(7'h7f, 8'h13, {6'h09, 1'h0, 7'h7f});
		rd("acc", cce_pkg::OFF_ACC, 32'hec);
		rd("file", cce_pkg::OFF_FILE_DATA, 32'h13);
		rd("status", cce_pkg::OFF_STATUS, 32'h0);
		op(7'h00, 8'hff, {6'h09, 1'h1, 7'h00});
		rd("file", cce_pkg::OFF_FILE_DATA, 32'h0);
		rd("acc", cce_pkg::OFF_ACC, 32'hec);
		rd("status", cce_pkg::OFF_STATUS, 32'h1);
	endtask
	// wrap from zero to all ones checks the borrow path
	task automatic t_dec();
		op(7'h05, 8'h01, {6'h03, 1'h1, 7'h05});
		rd("file", cce_pkg::OFF_FILE_DATA, 32'h0);
		rd("status", cce_pkg::OFF_STATUS, 32'h1);
		op(7'h05, 8'h00, {6'h03, 1'h0, 7'h05});
		rd("acc", cce_pkg::OFF_ACC, 32'hff);
		rd("file", cce_pkg::OFF_FILE_DATA, 32'h0);
		rd("status", cce_pkg::OFF_STATUS, 32'h0);
	endtask
	// zero flag must survive the watchdog clear either way
	task automatic t_wdog();
		chk("wd pulses", 32'h0, wdCount);
		apb(1'h1, cce_pkg::OFF_STATUS, 32'h1);
		apb(1'h1, cce_pkg::OFF_OPCODE, 32'h0064);
		rd("status", cce_pkg::OFF_STATUS, 32'h7);
		chk("flag pins", 32'h7, {29'h0, pdFlag, toFlag, nullFlag});
		apb(1'h1, cce_pkg::OFF_STATUS, 32'h0);
		apb(1'h1, cce_pkg::OFF_OPCODE, 32'h0064);
		rd("status", cce_pkg::OFF_STATUS, 32'h6);
		chk("flag pins", 32'h6, {29'h0, pdFlag, toFlag, nullFlag});
		chk("wd pulses", 32'h2, wdCount);
		chk("pres pulses", 32'h2, presCount);
		rd("acc", cce_pkg::OFF_ACC, 32'hff);
		rd("unmapped", 8'h20, 32'h0);
		chk("slverr", 32'h1, {31'h0, rdErr});
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		t_clear();
		t_comp();
		t_dec();
		t_wdog();
		t_none();
		close_out();
	end
	// some 40 transfers of 4 cycles each need under 3 us; allow ten times that
	initial begin
		#30000;
		errTotal++;
		close_out();
	end
endmodule
